// ### common/i2cab_map.svh
// Register map, field positions, reset values and bit counts of the abort and DMA block
`ifndef I2CAB_MAP_SVH
`define I2CAB_MAP_SVH

`define I2CAB_TX_FILL_COUNT_ADDR     32'h50001574
`define I2CAB_CAUSE_ADDR     32'h50001580
`define I2CAB_DMACR_ADDR     32'h50001588
`define I2CAB_TDLR_ADDR      32'h5000158c
`define I2CAB_RDLR_ADDR      32'h50001590
`define I2CAB_SDASETUP_ADDR  32'h50001594

`define I2CAB_B_10B_RD       10
`define I2CAB_B_SBYTE_NORST  9
`define I2CAB_B_HS_NORST     8
`define I2CAB_B_SBYTE_ACK    7
`define I2CAB_B_HS_ACK       6
`define I2CAB_B_GCALL_READ   5
`define I2CAB_B_GCALL_NACK   4
`define I2CAB_B_DATA_NACK    3
`define I2CAB_B_ADDR2_NACK   2
`define I2CAB_B_ADDR1_NACK   1
`define I2CAB_B_ADDR7_NACK   0

`define I2CAB_B_TX_GATE      1
`define I2CAB_B_RX_GATE      0

`define I2CAB_DMACR_RST      2'h0
`define I2CAB_TDLR_RST       5'h00
`define I2CAB_RDLR_RST       5'h00
`define I2CAB_SDASETUP_RST   8'h64

`define I2CAB_ACK_BIT        4'h8

`endif

// ### common/i2cab_pkg.sv
// Types of the abort and DMA block
package i2cab_pkg;

    typedef enum logic [3:0] {
        MON_IDLE,
        MON_SBYTE,
        MON_HSCODE,
        MON_GCALL,
        MON_ADDR7,
        MON_ADDR1,
        MON_ADDR2,
        MON_DATA,
        MON_WAIT
    } i2cab_mon_type;

    typedef struct packed {
        logic          sclS1;
        logic          sclS2;
        logic          sclPrev;
        logic          sdaS1;
        logic          sdaS2;
        logic          sdaPrev;
        i2cab_mon_type mon;
        logic [3:0]    bitCnt;
        logic          preDone;
        logic [15:0]   cause;
        logic [15:0]   pend;
        logic [1:0]    dmaCr;
        logic [4:0]    txLvl;
        logic [4:0]    rxLvl;
        logic [7:0]    sdaSetup;
        logic [31:0]   rdata;
        logic          ready;
        logic          slverr;
        logic          txReq;
        logic          rxReq;
        logic [15:0]   outData;
        logic          outValid;
        logic [15:0]   skidData;
        logic          skidValid;
    } i2cab_state_type;

endpackage

// ### hw/i2cab_abort_dma.sv
// Abort cause capture, DMA watermark requests and their APB registers
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "i2cab_map.svh"

module i2cab_abort_dma (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        repeatedStartAllow,
    input  wire logic        commandFlagA,
    input  wire logic        gencallOrStartbyteSelect,
    input  wire logic        highSpeedMode,
    input  wire logic        tenBitMode,
    input  wire logic        masterActive,
    input  wire logic        cmdIssue,
    input  wire logic        readCmd,
    input  wire logic        nextCmdRead,
    input  wire logic        txPending,
    input  wire logic        abortClear,
    input  wire logic        controllerEnable,
    input  wire logic  [5:0] txFillCount,
    input  wire logic  [5:0] rxFillCount,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             dmaTxReq,
    output logic             dmaRxReq,
    output logic       [7:0] sdaSetupDelay,
    output logic      [15:0] abtData,
    output logic             abtValid,
    input  wire logic        abtReady
);

    i2cab_pkg::i2cab_state_type st;
    i2cab_pkg::i2cab_state_type nx;

    logic        startByteReq;
    logic        gcallReq;
    logic        startCond;
    logic        stopCond;
    logic        sclRise;
    logic        ackSlot;
    logic        acked;
    logic [15:0] sets;
    logic        setup;
    logic        access;
    logic        addrHit;
    logic [31:0] rd;
    logic        push;
    logic        outFree;

    assign startByteReq = commandFlagA & gencallOrStartbyteSelect;
    assign gcallReq     = commandFlagA & ~gencallOrStartbyteSelect;
    // Edges are taken from the second sync stage against its delayed copy
    assign startCond    = st.sclS2 & st.sclPrev & st.sdaPrev & ~st.sdaS2;
    assign stopCond     = st.sclS2 & st.sclPrev & ~st.sdaPrev & st.sdaS2;
    assign sclRise      = st.sclS2 & ~st.sclPrev;
    assign ackSlot      = sclRise && (st.bitCnt == `I2CAB_ACK_BIT);
    assign acked        = ~st.sdaS2;
    assign setup        = psel & ~penable;
    assign access       = psel & penable & st.ready;

    always_comb
    begin
        addrHit = 1'b1;
        rd      = 32'h0;
        case (paddr)
            `I2CAB_TX_FILL_COUNT_ADDR:    rd[5:0]  = txFillCount;
            `I2CAB_CAUSE_ADDR:    rd[15:0] = st.cause;
            `I2CAB_DMACR_ADDR:    rd[1:0]  = st.dmaCr;
            `I2CAB_TDLR_ADDR:     rd[4:0]  = st.txLvl;
            `I2CAB_RDLR_ADDR:     rd[4:0]  = st.rxLvl;
            `I2CAB_SDASETUP_ADDR: rd[7:0]  = st.sdaSetup;
            default:              addrHit  = 1'b0;
        endcase
    end

    always_comb
    begin
        nx      = st;
        sets    = 16'h0;
        push    = 1'b0;
        outFree = 1'b0;

        nx.sclS1   = sclIn;
        nx.sclS2   = st.sclS1;
        nx.sclPrev = st.sclS2;
        nx.sdaS1   = sdaIn;
        nx.sdaS2   = st.sdaS1;
        nx.sdaPrev = st.sdaS2;

        // Restart-disabled checks act on the queued command
        if (cmdIssue && !repeatedStartAllow && tenBitMode && readCmd)
        begin
            sets[`I2CAB_B_10B_RD] = 1'b1;
        end
        // Level set, so a clear while the cause stands leaves the bit set
        if (txPending && !repeatedStartAllow && startByteReq)
        begin
            sets[`I2CAB_B_SBYTE_NORST] = 1'b1;
        end
        if (cmdIssue && !repeatedStartAllow && highSpeedMode)
        begin
            sets[`I2CAB_B_HS_NORST] = 1'b1;
        end

        // Bus monitor of our own master transfers
        if (sclRise)
        begin
            nx.bitCnt = st.bitCnt + 4'h1;
        end
        if (ackSlot)
        begin
            nx.bitCnt = 4'h0;
            case (st.mon)
                i2cab_pkg::MON_SBYTE:
                begin
                    if (acked)
                    begin
                        sets[`I2CAB_B_SBYTE_ACK] = 1'b1;
                    end
                    else
                    begin
                        nx.preDone = 1'b1;
                    end
                    nx.mon = i2cab_pkg::MON_WAIT;
                end
                i2cab_pkg::MON_HSCODE:
                begin
                    if (acked)
                    begin
                        sets[`I2CAB_B_HS_ACK] = 1'b1;
                    end
                    else
                    begin
                        nx.preDone = 1'b1;
                    end
                    nx.mon = i2cab_pkg::MON_WAIT;
                end
                i2cab_pkg::MON_GCALL:
                begin
                    if (!acked)
                    begin
                        sets[`I2CAB_B_GCALL_NACK] = 1'b1;
                        nx.mon = i2cab_pkg::MON_WAIT;
                    end
                    else if (nextCmdRead)
                    begin
                        sets[`I2CAB_B_GCALL_READ] = 1'b1;
                        nx.mon = i2cab_pkg::MON_WAIT;
                    end
                    else
                    begin
                        nx.mon = i2cab_pkg::MON_DATA;
                    end
                end
                i2cab_pkg::MON_ADDR7:
                begin
                    if (!acked)
                    begin
                        sets[`I2CAB_B_ADDR7_NACK] = 1'b1;
                        nx.mon = i2cab_pkg::MON_WAIT;
                    end
                    else
                    begin
                        nx.mon = i2cab_pkg::MON_DATA;
                    end
                end
                i2cab_pkg::MON_ADDR1:
                begin
                    if (!acked)
                    begin
                        sets[`I2CAB_B_ADDR1_NACK] = 1'b1;
                        nx.mon = i2cab_pkg::MON_WAIT;
                    end
                    else
                    begin
                        nx.mon = i2cab_pkg::MON_ADDR2;
                    end
                end
                i2cab_pkg::MON_ADDR2:
                begin
                    if (!acked)
                    begin
                        sets[`I2CAB_B_ADDR2_NACK] = 1'b1;
                        nx.mon = i2cab_pkg::MON_WAIT;
                    end
                    else
                    begin
                        nx.mon = i2cab_pkg::MON_DATA;
                    end
                end
                i2cab_pkg::MON_DATA:
                begin
                    // Reached only after the address was acknowledged
                    if (!acked)
                    begin
                        sets[`I2CAB_B_DATA_NACK] = 1'b1;
                        nx.mon = i2cab_pkg::MON_WAIT;
                    end
                end
                default:
                begin
                    nx.mon = st.mon;
                end
            endcase
        end
        if (startCond && masterActive)
        begin
            nx.bitCnt = 4'h0;
            if (st.preDone || (!startByteReq && !highSpeedMode && !gcallReq))
            begin
                nx.mon = tenBitMode ? i2cab_pkg::MON_ADDR1
                                    : i2cab_pkg::MON_ADDR7;
            end
            else if (startByteReq)
            begin
                nx.mon = i2cab_pkg::MON_SBYTE;
            end
            else if (highSpeedMode)
            begin
                nx.mon = i2cab_pkg::MON_HSCODE;
            end
            else
            begin
                nx.mon = i2cab_pkg::MON_GCALL;
            end
        end
        if (stopCond || !masterActive)
        begin
            nx.mon     = i2cab_pkg::MON_IDLE;
            nx.preDone = 1'b0;
            nx.bitCnt  = 4'h0;
        end

        // Set wins over the clear in the same cycle
        nx.cause = (abortClear ? 16'h0 : st.cause) | sets;

        // Abort records: pending bits merge while the buffer is full
        push = (st.pend != 16'h0) && !st.skidValid;
        nx.pend = (push ? 16'h0 : st.pend) | sets;
        outFree = !st.outValid || abtReady;
        if (st.outValid && abtReady)
        begin
            nx.outValid  = st.skidValid;
            nx.outData   = st.skidData;
            nx.skidValid = 1'b0;
            outFree      = !st.skidValid;
        end
        if (push)
        begin
            if (outFree)
            begin
                nx.outValid = 1'b1;
                nx.outData  = st.pend;
            end
            else
            begin
                nx.skidValid = 1'b1;
                nx.skidData  = st.pend;
            end
        end

        // DMA watermark requests
        nx.txReq = st.dmaCr[`I2CAB_B_TX_GATE]
                   && (txFillCount <= {1'b0, st.txLvl});
        nx.rxReq = st.dmaCr[`I2CAB_B_RX_GATE]
                   && (rxFillCount >= 6'({1'b0, st.rxLvl} + 6'h1));

        // APB: one wait-free access phase after every setup
        nx.ready = setup;
        if (setup)
        begin
            nx.rdata  = pwrite ? 32'h0 : rd;
            nx.slverr = !addrHit;
        end
        else if (!psel)
        begin
            nx.slverr = 1'b0;
        end
        if (access && pwrite)
        begin
            case (paddr)
                `I2CAB_DMACR_ADDR: nx.dmaCr = pwdata[1:0];
                `I2CAB_TDLR_ADDR:  nx.txLvl = pwdata[4:0];
                `I2CAB_RDLR_ADDR:  nx.rxLvl = pwdata[4:0];
                `I2CAB_SDASETUP_ADDR:
                begin
                    // Timing change only while the controller is off
                    if (!controllerEnable)
                    begin
                        nx.sdaSetup = pwdata[7:0];
                    end
                end
                default:
                begin
                    nx.dmaCr = st.dmaCr;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st          <= '0;
            st.sclS1    <= 1'b1;
            st.sclS2    <= 1'b1;
            st.sclPrev  <= 1'b1;
            st.sdaS1    <= 1'b1;
            st.sdaS2    <= 1'b1;
            st.sdaPrev  <= 1'b1;
            st.mon      <= i2cab_pkg::MON_IDLE;
            st.dmaCr    <= `I2CAB_DMACR_RST;
            st.txLvl    <= `I2CAB_TDLR_RST;
            st.rxLvl    <= `I2CAB_RDLR_RST;
            st.sdaSetup <= `I2CAB_SDASETUP_RST;
        end
        else
        begin
            st <= nx;
        end
    end

    assign prdata        = st.rdata;
    assign pready        = st.ready;
    assign pslverr       = st.slverr;
    assign dmaTxReq      = st.txReq;
    assign dmaRxReq      = st.rxReq;
    assign sdaSetupDelay = st.sdaSetup;
    assign abtData       = st.outData;
    assign abtValid      = st.outValid;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence apbSetupSeq;
        psel && !penable;
    endsequence

    sequence apbAccessSeq;
        psel && penable && pready;
    endsequence

    norst_tenbit_a:
        assert property (cmdIssue && !repeatedStartAllow && tenBitMode
                         && readCmd |=> st.cause[`I2CAB_B_10B_RD])
        else $error("10-bit read without restart not recorded");

    sbyte_reassert_a:
        assert property (txPending && !repeatedStartAllow && startByteReq
                         && abortClear |=> st.cause[`I2CAB_B_SBYTE_NORST])
        else $error("start byte cause lost while still present");

    norst_hs_a:
        assert property (cmdIssue && !repeatedStartAllow && highSpeedMode
                         |=> st.cause[`I2CAB_B_HS_NORST])
        else $error("high speed without restart not recorded");

    addr7_nack_a:
        assert property (ackSlot && st.sdaS2
                         && st.mon == i2cab_pkg::MON_ADDR7
                         && !startCond && !abortClear
                         |=> st.cause[`I2CAB_B_ADDR7_NACK]
                             && st.mon != i2cab_pkg::MON_DATA)
        else $error("7-bit address nack not recorded");

    cause_hold_a:
        assert property (!abortClear && !$past(abortClear)
                         |-> (st.cause & $past(st.cause)) == $past(st.cause))
        else $error("cause bit dropped without clear");

    tx_gate_off_a:
        assert property (!st.dmaCr[`I2CAB_B_TX_GATE][*2] |-> !dmaTxReq)
        else $error("transmit request while gated off");

    tx_level_a:
        assert property (st.dmaCr[`I2CAB_B_TX_GATE]
                         && txFillCount <= {1'b0, st.txLvl}
                         |=> dmaTxReq)
        else $error("transmit request missing at watermark");

    rx_level_a:
        assert property (dmaRxReq |-> $past(st.dmaCr[`I2CAB_B_RX_GATE])
                         && $past(rxFillCount) > {1'b0, $past(st.rxLvl)})
        else $error("receive request below watermark");

    rx_gate_off_a:
        assert property (!st.dmaCr[`I2CAB_B_RX_GATE][*2] |-> !dmaRxReq)
        else $error("receive request while gated off");

    fill_read_a:
        assert property (apbSetupSeq ##0 (!pwrite
                         && paddr == `I2CAB_TX_FILL_COUNT_ADDR)
                         |=> apbAccessSeq ##0
                             prdata == {26'h0, $past(txFillCount)})
        else $error("fill count read back wrong");

endmodule

// ### tb/i2cab_bus_model.sv
// Remote two-wire bus: drives frames on SCL and SDA with chosen acknowledges
`timescale 1ns/100ps

module i2cab_bus_model (
    output logic sclLine,
    output logic sdaLine
);

    // Both lines have pull-ups: released or idle means high, SCL still
    initial
    begin
        sclLine = 1'b1;
        sdaLine = 1'b1;
    end

    // One START, nb bytes, then STOP; ack bit b high acknowledges byte b
    task automatic frame(input logic [1:0] nb, input logic [1:0] ack);
        logic [7:0] pat;
        pat = 8'h5a;
        #3 sdaLine = 1'b0;
        #80 sclLine = 1'b0;
        for (int b = 0; b < nb; b++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                #40 sdaLine = (i == 8) ? !ack[b] : pat[7 - i];
                #40 sclLine = 1'b1;
                #80 sclLine = 1'b0;
            end
        end
        #40 sdaLine = 1'b0;
        #40 sclLine = 1'b1;
        #80 sdaLine = 1'b1;
    endtask

endmodule

// ### tb/i2cab_abort_dma_test.sv
// Self-checking bench of the abort cause and DMA request block
`timescale 1ns/100ps
`include "i2cab_map.svh"

module i2cab_abort_dma_test;

    typedef struct packed {
        logic [4:0]  mode;
        logic [1:0]  nb;
        logic [1:0]  ack;
        logic [15:0] exp;
    } i2cab_row_type;

    logic          sys_clk;
    logic          rst_n;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [31:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          repeatedStartAllow;
    logic          commandFlagA;
    logic          gencallOrStartbyteSelect;
    logic          highSpeedMode;
    logic          tenBitMode;
    logic          masterActive;
    logic          cmdIssue;
    logic          readCmd;
    logic          nextCmdRead;
    logic          txPending;
    logic          abortClear;
    logic          controllerEnable;
    logic [5:0]    txFillCount;
    logic [5:0]    rxFillCount;
    wire           sclLine;
    wire           sdaLine;
    logic          dmaTxReq;
    logic          dmaRxReq;
    logic [7:0]    sdaSetupDelay;
    logic [15:0]   abtData;
    logic          abtValid;
    logic          abtReady;
    logic [31:0]   rdat;
    logic          rerr;
    logic [15:0]   acc;
    int            nErrors;
    int            checksDone;
    i2cab_row_type rows [8];
    logic [31:0]   regAddr [5];
    logic [31:0]   regRst [5];

    i2cab_bus_model bus (
        .sclLine (sclLine),
        .sdaLine (sdaLine)
    );

    i2cab_abort_dma dut (
        .sys_clk                  (sys_clk),
        .rst_n                    (rst_n),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .prdata                   (prdata),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .repeatedStartAllow       (repeatedStartAllow),
        .commandFlagA             (commandFlagA),
        .gencallOrStartbyteSelect (gencallOrStartbyteSelect),
        .highSpeedMode            (highSpeedMode),
        .tenBitMode               (tenBitMode),
        .masterActive             (masterActive),
        .cmdIssue                 (cmdIssue),
        .readCmd                  (readCmd),
        .nextCmdRead              (nextCmdRead),
        .txPending                (txPending),
        .abortClear               (abortClear),
        .controllerEnable         (controllerEnable),
        .txFillCount              (txFillCount),
        .rxFillCount              (rxFillCount),
        .sclIn                    (sclLine),
        .sdaIn                    (sdaLine),
        .dmaTxReq                 (dmaTxReq),
        .dmaRxReq                 (dmaRxReq),
        .sdaSetupDelay            (sdaSetupDelay),
        .abtData                  (abtData),
        .abtValid                 (abtValid),
        .abtReady                 (abtReady)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic finishTest();
        $display("checks %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits for pready under a bound; a hang counts as a mismatch
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            nErrors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulseClear();
        @(posedge sys_clk);
        abortClear <= 1'b1;
        @(posedge sys_clk);
        abortClear <= 1'b0;
    endtask

    task automatic pulseIssue();
        @(posedge sys_clk);
        cmdIssue <= 1'b1;
        @(posedge sys_clk);
        cmdIssue <= 1'b0;
    endtask

    initial
    begin
        #200000;
        nErrors++;
        finishTest();
    end

    initial
    begin
        // Mode is {flag, select, high speed, 10-bit, next read}
        rows = '{'{5'b00000, 2'd1, 2'b00, 16'h0001},
                 '{5'b00010, 2'd1, 2'b00, 16'h0002},
                 '{5'b00010, 2'd2, 2'b01, 16'h0004},
                 '{5'b00000, 2'd2, 2'b01, 16'h0008},
                 '{5'b10000, 2'd1, 2'b00, 16'h0010},
                 '{5'b10001, 2'd1, 2'b01, 16'h0020},
                 '{5'b00100, 2'd1, 2'b01, 16'h0040},
                 '{5'b11000, 2'd1, 2'b01, 16'h0080}};
        regAddr = '{`I2CAB_CAUSE_ADDR, `I2CAB_DMACR_ADDR, `I2CAB_TDLR_ADDR,
                    `I2CAB_RDLR_ADDR, `I2CAB_SDASETUP_ADDR};
        regRst = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h64};
        {psel, penable, pwrite, cmdIssue, abortClear} = 5'h00;
        {readCmd, nextCmdRead, txPending, masterActive} = 4'h0;
        {commandFlagA, gencallOrStartbyteSelect} = 2'h0;
        {highSpeedMode, tenBitMode, controllerEnable} = 3'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeatedStartAllow = 1'b1;
        txFillCount = 6'h00;
        rxFillCount = 6'h00;
        abtReady = 1'b0;
        nErrors = 0;
        checksDone = 0;
        rst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        check("setup pin", 32'(sdaSetupDelay), 32'h64);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, regAddr[i], 32'h0);
            check("reset value", rdat, regRst[i]);
        end
        apb(1'b0, 32'h50001600, 32'h0);
        check("unmapped error", 32'(rerr), 32'h1);
        check("unmapped data", rdat, 32'h0);
        apb(1'b1, `I2CAB_CAUSE_ADDR, 32'hffff);
        apb(1'b0, `I2CAB_CAUSE_ADDR, 32'h0);
        check("cause read only", rdat, 32'h0);
        // Stream consumer stalls here so the buffer fills and must merge
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            {commandFlagA, gencallOrStartbyteSelect, highSpeedMode,
             tenBitMode, nextCmdRead} <= rows[i].mode;
            masterActive <= 1'b1;
            @(posedge sys_clk);
            bus.frame(rows[i].nb, rows[i].ack);
            repeat (8) @(posedge sys_clk);
            apb(1'b0, `I2CAB_CAUSE_ADDR, 32'h0);
            check("bus abort", rdat, 32'(rows[i].exp));
            masterActive <= 1'b0;
            pulseClear();
            apb(1'b0, `I2CAB_CAUSE_ADDR, 32'h0);
            check("cleared", rdat, 32'h0);
        end
        repeatedStartAllow <= 1'b0;
        tenBitMode <= 1'b1;
        readCmd <= 1'b1;
        pulseIssue();
        apb(1'b0, `I2CAB_CAUSE_ADDR, 32'h0);
        check("10-bit read", rdat, 32'h0400);
        pulseClear();
        tenBitMode <= 1'b0;
        highSpeedMode <= 1'b1;
        pulseIssue();
        apb(1'b0, `I2CAB_CAUSE_ADDR, 32'h0);
        check("high speed", rdat, 32'h0100);
        highSpeedMode <= 1'b0;
        pulseClear();
        txPending <= 1'b1;
        pulseClear();
        repeat (2) @(posedge sys_clk);
        apb(1'b0, `I2CAB_CAUSE_ADDR, 32'h0);
        check("start byte held", rdat, 32'h0200);
        repeatedStartAllow <= 1'b1;
        pulseClear();
        apb(1'b0, `I2CAB_CAUSE_ADDR, 32'h0);
        check("start byte fixed", rdat, 32'h0);
        txPending <= 1'b0;
        check("buffer full", 32'(abtValid), 32'h1);
        acc = 16'h0;
        abtReady <= 1'b1;
        repeat (16)
        begin
            @(posedge sys_clk);
            if (abtValid === 1'b1)
                acc = acc | abtData;
        end
        check("records merged", 32'(acc), 32'h07ff);
        check("buffer empty", 32'(abtValid), 32'h0);
        apb(1'b1, `I2CAB_TDLR_ADDR, 32'h5);
        apb(1'b1, `I2CAB_RDLR_ADDR, 32'h3);
        for (int g = 0; g < 4; g++)
        begin
            apb(1'b1, `I2CAB_DMACR_ADDR, 32'(g));
            apb(1'b0, `I2CAB_DMACR_ADDR, 32'h0);
            check("gates", rdat, 32'(g));
            for (int f = 0; f < 8; f++)
            begin
                txFillCount <= 6'(f);
                rxFillCount <= 6'(f);
                apb(1'b0, `I2CAB_TX_FILL_COUNT_ADDR, 32'h0);
                check("fill count", rdat, 32'(f));
                check("tx req", 32'(dmaTxReq), 32'(g[1] && f <= 5));
                check("rx req", 32'(dmaRxReq), 32'(g[0] && f >= 4));
            end
        end
        controllerEnable <= 1'b1;
        apb(1'b1, `I2CAB_SDASETUP_ADDR, 32'h20);
        apb(1'b0, `I2CAB_SDASETUP_ADDR, 32'h0);
        check("setup locked", rdat, 32'h64);
        controllerEnable <= 1'b0;
        apb(1'b1, `I2CAB_SDASETUP_ADDR, 32'h20);
        apb(1'b0, `I2CAB_SDASETUP_ADDR, 32'h0);
        check("setup written", rdat, 32'h20);
        check("setup pin set", 32'(sdaSetupDelay), 32'h20);
        finishTest();
    end

endmodule
